// >>> core/ufci_consts.svh
// offsets, field positions, reset values and trigger tables of the uart fifo/interrupt block
`ifndef UFCI_CONSTS_SVH
`define UFCI_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define UFCI_OFS_FCTL   8'h00
`define UFCI_OFS_ISTAT  8'h04
`define UFCI_OFS_IEN    8'h08
`define UFCI_OFS_RXLVL  8'h0C
`define UFCI_OFS_TXLVL  8'h10
`define UFCI_OFS_FLOLO  8'h14
`define UFCI_OFS_FLOHI  8'h18
`define UFCI_OFS_EFEAT  8'h1C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFCI_FC_EN      0
`define UFCI_FC_RXCLR   1
`define UFCI_FC_TXCLR   2
`define UFCI_EF_ENH     4
`define UFCI_IE_RX      0
`define UFCI_IE_TXE     1
`define UFCI_IE_LINE    2
`define UFCI_IE_MODEM   3
`define UFCI_IE_XOFF    5

// ------------------------------------------------------------
// reset values and status codes
// ------------------------------------------------------------
`define UFCI_RST_REG    8'h00
`define UFCI_RST_ISTAT  8'h01
`define UFCI_CODE_NONE  6'h01
`define UFCI_CODE_LINE  6'h06
`define UFCI_CODE_RX    6'h04
`define UFCI_CODE_RXTO  6'h0C
`define UFCI_CODE_TXE   6'h02
`define UFCI_CODE_MODEM 6'h00
`define UFCI_CODE_XOFF  6'h10
`define UFCI_CODE_CTS   6'h20

// ------------------------------------------------------------
// trigger tables in 32-byte mode
// ------------------------------------------------------------
`define UFCI_RX_L0      8'h08
`define UFCI_RX_L1      8'h10
`define UFCI_RX_L2      8'h18
`define UFCI_RX_L3      8'h1C
`define UFCI_TX_L0      8'h10
`define UFCI_TX_L1      8'h08
`define UFCI_TX_L2      8'h18
`define UFCI_TX_L3      8'h1E

`endif

// >>> core/ufci_pkg.sv
// types of the uart fifo/interrupt block
`default_nettype none

package ufci_pkg;

   typedef enum logic [2:0] {
      LV_NONE, LV_LINE, LV_RX, LV_RXTO, LV_TXE, LV_MODEM, LV_XOFF, LV_CTS
   } ufci_lvl_t;

   typedef struct packed {
      logic [7:0]  fctl;
      logic [7:0]  ien;
      logic [7:0]  rxlvl;
      logic [7:0]  txlvl;
      logic [7:0]  flolo;
      logic [7:0]  flohi;
      logic [7:0]  efeat;
      ufci_lvl_t   cur;
      logic [7:0]  istat;
      logic        txe_int;
      logic        tx_prev;
      logic        xoff;
      logic        spec;
      logic        rx_rdy;
      logic        tx_rdy;
      logic        pending;
      logic [7:0]  rxtrig;
      logic [7:0]  txtrig;
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } ufci_state_t;

endpackage : ufci_pkg

`default_nettype wire

// >>> core/ufci_level_sel.sv
// trigger level selector: 2-bit table code or level register
`default_nettype none

module ufci_level_sel
#(
   parameter logic [7:0] L0 = 8'h08,
   parameter logic [7:0] L1 = 8'h10,
   parameter logic [7:0] L2 = 8'h18,
   parameter logic [7:0] L3 = 8'h1C
)
(
   input  wire logic [1:0] code,     // table code from fifo_control
   input  wire logic       use_ext,  // level registers take over
   input  wire logic [7:0] ext,      // level register value
   output logic      [7:0] level     // chosen trigger level
);

   always_comb
   begin
      if (use_ext)
      begin
         level = ext;
      end
      else
      begin
         unique case (code)
            2'b00: level = L0;
            2'b01: level = L1;
            2'b10: level = L2;
            2'b11: level = L3;
         endcase
      end
   end

endmodule : ufci_level_sel

`default_nettype wire

// >>> core/ufci_top.sv
// fifo control register and prioritised interrupt status behind an apb slave
//
// Chosen here: the placing of the registers and the APB slave port.
`include "ufci_consts.svh"
`default_nettype none

module ufci_top
   import ufci_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input  wire logic             pclk,            // bus clock
   input  wire logic             presetn,         // async reset, active low
   input  wire logic             psel,            // apb select
   input  wire logic             penable,         // apb access phase
   input  wire logic             pwrite,          // apb direction
   input  wire logic [7:0]       paddr,           // apb byte address
   input  wire logic [31:0]      pwdata,          // apb write data
   output logic      [31:0]      prdata,          // apb read data
   output logic                  pready,          // apb ready
   output logic                  pslverr,         // apb error
   input  wire logic [CNT_W-1:0] rx_count,        // chars in receive fifo
   input  wire logic [CNT_W-1:0] tx_count,        // chars in transmit fifo
   input  wire logic             rhr_full,        // receive holding reg has data
   input  wire logic             txh_empty,       // transmit holding reg empty
   input  wire logic             txh_write,       // pulse: char written to holding
   input  wire logic             line_err,        // line status condition
   input  wire logic             rx_timeout,      // receive data time-out
   input  wire logic             modem_change,    // modem status change
   input  wire logic             xoff_detect,     // pulse: xoff matched
   input  wire logic             xon_detect,      // pulse: xon matched
   input  wire logic             special_detect,  // pulse: special char matched
   input  wire logic             cts_rts_change,  // cts/rts change of state
   output logic                  fifo_enable,     // both fifos enabled
   output logic                  tx_flush,        // pulse: empty transmit fifo
   output logic                  rx_flush,        // pulse: empty receive fifo
   output logic      [7:0]       rx_trig_level,   // receive trigger in bytes
   output logic      [7:0]       tx_trig_level,   // transmit trigger in bytes
   output logic                  receive_ready,   // receive readiness
   output logic                  transmit_ready,  // transmit readiness
   output logic                  int_pending      // some interrupt reported
);

   // ------------------------------------------------------------
   // state and helpers
   // ------------------------------------------------------------
   ufci_state_t s_q;
   ufci_state_t s_d;
   logic [7:0]  rx_lvl;
   logic [7:0]  tx_lvl;
   logic        use_ext;
   logic        acc;
   logic        fin;
   logic        wr_fin;
   logic        rd_istat;
   logic        enh;
   logic        rx_cond;
   logic        tx_cond;
   logic [7:0]  pend;
   ufci_lvl_t   best;

   function automatic logic [5:0] lvl_code(input ufci_lvl_t l);
      unique case (l)
         LV_NONE:  lvl_code = `UFCI_CODE_NONE;
         LV_LINE:  lvl_code = `UFCI_CODE_LINE;
         LV_RX:    lvl_code = `UFCI_CODE_RX;
         LV_RXTO:  lvl_code = `UFCI_CODE_RXTO;
         LV_TXE:   lvl_code = `UFCI_CODE_TXE;
         LV_MODEM: lvl_code = `UFCI_CODE_MODEM;
         LV_XOFF:  lvl_code = `UFCI_CODE_XOFF;
         LV_CTS:   lvl_code = `UFCI_CODE_CTS;
      endcase
   endfunction : lvl_code

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one wait state: ready rises in the second access cycle
   assign acc      = psel && penable && !s_q.ready;
   assign fin      = psel && penable && s_q.ready;
   assign wr_fin   = fin && pwrite;
   assign rd_istat = fin && !pwrite && paddr == `UFCI_OFS_ISTAT;
   assign enh      = s_q.efeat[`UFCI_EF_ENH];

   // nonzero threshold registers hand triggers to the level registers
   assign use_ext = |{s_q.rxlvl, s_q.txlvl, s_q.flolo, s_q.flohi};

   ufci_level_sel #(
      .L0 (`UFCI_RX_L0),
      .L1 (`UFCI_RX_L1),
      .L2 (`UFCI_RX_L2),
      .L3 (`UFCI_RX_L3)
   ) u_rx_sel (
      .code    (s_q.fctl[7:6]),
      .use_ext (use_ext),
      .ext     (s_q.rxlvl),
      .level   (rx_lvl)
   );

   ufci_level_sel #(
      .L0 (`UFCI_TX_L0),
      .L1 (`UFCI_TX_L1),
      .L2 (`UFCI_TX_L2),
      .L3 (`UFCI_TX_L3)
   ) u_tx_sel (
      .code    (s_q.fctl[5:4]),
      .use_ext (use_ext),
      .ext     (s_q.txlvl),
      .level   (tx_lvl)
   );

   // ------------------------------------------------------------
   // readiness and pending sources
   // ------------------------------------------------------------
   always_comb
   begin
      if (s_q.fctl[`UFCI_FC_EN])
      begin
         rx_cond = 8'(rx_count) >= s_q.rxtrig;
         tx_cond = 8'(tx_count) < s_q.txtrig;
      end
      else
      begin
         rx_cond = rhr_full;
         tx_cond = txh_empty;
      end
      pend          = 8'h00;
      pend[LV_LINE]  = s_q.ien[`UFCI_IE_LINE] && line_err;
      pend[LV_RX]    = s_q.ien[`UFCI_IE_RX] && rx_cond;
      pend[LV_RXTO]  = s_q.ien[`UFCI_IE_RX] && rx_timeout;
      pend[LV_TXE]   = s_q.ien[`UFCI_IE_TXE] && s_q.txe_int;
      pend[LV_MODEM] = s_q.ien[`UFCI_IE_MODEM] && modem_change;
      // priorities 6 and 7 exist only in enhanced mode
      pend[LV_XOFF] = enh && s_q.ien[`UFCI_IE_XOFF] && (s_q.xoff || s_q.spec);
      pend[LV_CTS]  = enh && (|s_q.ien[7:6]) && cts_rts_change;
      best = LV_NONE;
      for (int i = 7; i >= 1; i--)
      begin
         if (pend[i])
         begin
            best = ufci_lvl_t'(i[2:0]);
         end
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.ready  = acc;
      s_d.rxtrig = rx_lvl;
      s_d.txtrig = tx_lvl;
      s_d.rx_rdy = rx_cond;
      s_d.tx_rdy = tx_cond;
      // flush bits live one cycle, so they read back as zero once done
      s_d.fctl[`UFCI_FC_TXCLR] = 1'b0;
      s_d.fctl[`UFCI_FC_RXCLR] = 1'b0;
      s_d.tx_prev = tx_cond;

      // reported level is held while its source stays pending
      if (s_q.cur == LV_NONE || !pend[s_q.cur])
      begin
         s_d.cur = best;
      end
      s_d.istat[7:6] = {2{s_q.fctl[`UFCI_FC_EN]}};
      s_d.istat[5:0] = lvl_code(s_q.cur);
      s_d.pending    = s_q.cur != LV_NONE;

      if (acc)
      begin
         s_d.slverr = 1'b0;
         s_d.rdata  = 32'h0000_0000;
         unique case (paddr)
            `UFCI_OFS_FCTL:  s_d.rdata[7:0] = s_q.fctl;
            `UFCI_OFS_ISTAT: s_d.rdata[7:0] = s_q.istat;
            `UFCI_OFS_IEN:   s_d.rdata[7:0] = s_q.ien;
            `UFCI_OFS_RXLVL: s_d.rdata[7:0] = s_q.rxlvl;
            `UFCI_OFS_TXLVL: s_d.rdata[7:0] = s_q.txlvl;
            `UFCI_OFS_FLOLO: s_d.rdata[7:0] = s_q.flolo;
            `UFCI_OFS_FLOHI: s_d.rdata[7:0] = s_q.flohi;
            `UFCI_OFS_EFEAT: s_d.rdata[7:0] = s_q.efeat;
            default:         s_d.slverr     = 1'b1;
         endcase
      end

      if (wr_fin)
      begin
         unique case (paddr)
            `UFCI_OFS_FCTL:
            begin
               s_d.fctl      = pwdata[7:0];
               s_d.fctl[3]   = 1'b0;
            end
            `UFCI_OFS_IEN:   s_d.ien   = pwdata[7:0];
            `UFCI_OFS_RXLVL: s_d.rxlvl = pwdata[7:0];
            `UFCI_OFS_TXLVL: s_d.txlvl = pwdata[7:0];
            `UFCI_OFS_FLOLO: s_d.flolo = pwdata[7:0];
            `UFCI_OFS_FLOHI: s_d.flohi = pwdata[7:0];
            `UFCI_OFS_EFEAT: s_d.efeat = pwdata[7:0];
            default:         s_d.efeat = s_q.efeat;
         endcase
      end

      // clears first, sets last: an event in the clearing cycle wins
      if (txh_write || (rd_istat && s_q.cur == LV_TXE))
      begin
         s_d.txe_int = 1'b0;
      end
      if (tx_cond && !s_q.tx_prev)
      begin
         s_d.txe_int = 1'b1;
      end
      if (rd_istat && s_q.cur == LV_XOFF)
      begin
         s_d.spec = 1'b0;
      end
      if (special_detect)
      begin
         s_d.spec = 1'b1;
      end
      if (xon_detect)
      begin
         s_d.xoff = 1'b0;
      end
      if (xoff_detect)
      begin
         s_d.xoff = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q        <= '0;
         s_q.fctl   <= `UFCI_RST_REG;
         s_q.istat  <= `UFCI_RST_ISTAT;
         s_q.cur    <= LV_NONE;
         s_q.rxtrig <= `UFCI_RX_L0;
         s_q.txtrig <= `UFCI_TX_L0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata         = s_q.rdata;
   assign pready         = s_q.ready;
   assign pslverr        = s_q.slverr;
   assign fifo_enable    = s_q.fctl[`UFCI_FC_EN];
   assign tx_flush       = s_q.fctl[`UFCI_FC_TXCLR];
   assign rx_flush       = s_q.fctl[`UFCI_FC_RXCLR];
   assign rx_trig_level  = s_q.rxtrig;
   assign tx_trig_level  = s_q.txtrig;
   assign receive_ready  = s_q.rx_rdy;
   assign transmit_ready = s_q.tx_rdy;
   assign int_pending    = s_q.pending;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr_fctl;
   assign wr_fctl = wr_fin && paddr == `UFCI_OFS_FCTL;

   AST_FIFO_EN: assert property (wr_fctl |=> fifo_enable == $past(pwdata[0]))
      else $error("fifo enable does not follow write");
   AST_TX_FLUSH: assert property (wr_fctl && pwdata[2] |=> tx_flush ##1 !tx_flush)
      else $error("transmit flush not a single pulse");
   AST_RX_FLUSH: assert property (wr_fctl && pwdata[1] |=> rx_flush ##1 !rx_flush)
      else $error("receive flush not a single pulse");
   AST_RX_TRIG28: assert property (!use_ext && s_q.fctl[7:6] == 2'b11
      |=> rx_trig_level == 8'h1C)
      else $error("receive trigger code 11 not 28");
   AST_TX_TRIG30: assert property (!use_ext && s_q.fctl[5:4] == 2'b11
      |=> tx_trig_level == 8'h1E)
      else $error("transmit trigger code 11 not 30");
   AST_RX_READY: assert property (fifo_enable && 8'(rx_count) >= rx_trig_level
      |=> receive_ready)
      else $error("receive ready missed at trigger");
   AST_TX_READY: assert property (fifo_enable && 8'(tx_count) < tx_trig_level
      |=> transmit_ready)
      else $error("transmit ready missed below trigger");
   AST_EXT_LVL: assert property (use_ext |=> rx_trig_level == $past(s_q.rxlvl))
      else $error("level register not used as trigger");
   AST_HOLD: assert property (s_q.cur != LV_NONE && pend[s_q.cur] |=> $stable(s_q.cur))
      else $error("reported interrupt changed while pending");
   AST_LINE_CODE: assert property (s_q.cur == LV_LINE |=> s_q.istat[5:0] == 6'h06)
      else $error("line status code wrong");
   AST_FIFO_BITS: assert property (##1 s_q.istat[7:6] == {2{$past(fifo_enable)}})
      else $error("status bits 7:6 do not track fifo enable");
   AST_ENH_GATE: assert property (!enh |=> !(s_q.cur inside {LV_XOFF, LV_CTS}))
      else $error("enhanced source reported while disabled");
   AST_XOFF_STICKY: assert property (s_q.xoff && !xon_detect |=> s_q.xoff)
      else $error("xoff status dropped without xon");
   AST_PEND_BIT: assert property (s_q.cur == LV_MODEM
      |=> int_pending && s_q.istat[5:0] == 6'h00)
      else $error("modem status not shown as pending");
   AST_TXE_CLR: assert property (txh_write && !(tx_cond && !s_q.tx_prev)
      |=> !s_q.txe_int)
      else $error("transmit empty not cleared by write");

   // ------------------------------------------------------------
   // code table and readiness checks
   // ------------------------------------------------------------
   AST_RX_TRIG8: assert property (!use_ext && s_q.fctl[7:6] == 2'b00
      |=> rx_trig_level == 8'h08)
      else $error("receive trigger code 00 not 8");
   AST_TX_TRIG16: assert property (!use_ext && s_q.fctl[5:4] == 2'b00
      |=> tx_trig_level == 8'h10)
      else $error("transmit trigger code 00 not 16");
   AST_RX_BELOW: assert property (fifo_enable && 8'(rx_count) < rx_trig_level
      |=> !receive_ready)
      else $error("receive ready set below trigger");
   AST_RX_RDY_OFF: assert property (!fifo_enable
      |=> receive_ready == $past(rhr_full))
      else $error("receive ready not following holding register");
   AST_TX_RDY_OFF: assert property (!fifo_enable
      |=> transmit_ready == $past(txh_empty))
      else $error("transmit ready not following holding register");
   AST_PRIO: assert property (s_q.cur == LV_NONE |=> s_q.cur == $past(best))
      else $error("idle status did not take the best pending level");
   AST_RX_CODE: assert property (s_q.cur == LV_RX |=> s_q.istat[5:0] == 6'h04)
      else $error("receive data ready code wrong");
   AST_RXTO_CODE: assert property (s_q.cur == LV_RXTO |=> s_q.istat[5:0] == 6'h0C)
      else $error("receive time-out code wrong");
   AST_TXE_CODE: assert property (s_q.cur == LV_TXE |=> s_q.istat[5:0] == 6'h02)
      else $error("transmit empty code wrong");
   AST_XOFF_CODE: assert property (s_q.cur == LV_XOFF |=> s_q.istat[5:0] == 6'h10)
      else $error("xoff or special code wrong");
   AST_CTS_CODE: assert property (s_q.cur == LV_CTS |=> s_q.istat[5:0] == 6'h20)
      else $error("cts/rts change code wrong");
   AST_NONE_BIT: assert property (s_q.cur == LV_NONE
      |=> s_q.istat[0] && !int_pending)
      else $error("idle status bit 0 not set");
   AST_FLUSH_IDLE: assert property (!wr_fctl |=> !tx_flush && !rx_flush)
      else $error("flush pulse without a write");

   COV_ISTAT_READ: cover property (rd_istat && s_q.cur == LV_TXE);
   COV_FLUSH_BOTH: cover property (tx_flush && rx_flush);
   COV_PREEMPT_LOW: cover property (s_q.cur == LV_LINE ##1 s_q.cur == LV_RX);
   COV_RX_TIMEOUT: cover property (s_q.cur == LV_RXTO);
   COV_NONFIFO_RX: cover property (!fifo_enable && s_q.cur == LV_RX);

endmodule : ufci_top

`default_nettype wire

// >>> verification/ufci_apb_host.sv
// apb master model standing in for the host processor
`default_nettype none

module ufci_apb_host
(
   input  wire logic        pclk,     // bus clock
   output logic             psel,     // select
   output logic             penable,  // access phase
   output logic             pwrite,   // direction
   output logic [7:0]       paddr,    // byte address
   output logic [31:0]      pwdata,   // write data
   input  wire logic [31:0] prdata,   // read data
   input  wire logic        pready,   // slave ready
   input  wire logic        pslverr   // slave error
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // request held until pready is seen at a rising edge; the bench watchdog bounds the wait
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

endmodule : ufci_apb_host

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench of the fifo control and interrupt status block
`include "ufci_consts.svh"
`default_nettype none

module tb
   import ufci_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, rx_count, tx_count, rx_trig_level, tx_trig_level;
   logic [31:0] pwdata, prdata, got;
   logic        rhr_full, txh_empty, txh_write, line_err, rx_timeout, modem_change;
   logic        xoff_detect, xon_detect, special_detect, cts_rts_change;
   logic        fifo_enable, tx_flush, rx_flush, receive_ready, transmit_ready, int_pending;
   int          n_errors = 0;
   int          check_count = 0;
   logic [7:0]  rxt [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
   logic [7:0]  txt [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
   logic [7:0]  ofs [4] = '{`UFCI_OFS_RXLVL, `UFCI_OFS_TXLVL, `UFCI_OFS_FLOLO, `UFCI_OFS_FLOHI};

   always #4 pclk = ~pclk;

   ufci_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   ufci_top #(.CNT_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_count(rx_count), .tx_count(tx_count),
      .rhr_full(rhr_full), .txh_empty(txh_empty), .txh_write(txh_write),
      .line_err(line_err), .rx_timeout(rx_timeout), .modem_change(modem_change),
      .xoff_detect(xoff_detect), .xon_detect(xon_detect), .special_detect(special_detect),
      .cts_rts_change(cts_rts_change), .fifo_enable(fifo_enable), .tx_flush(tx_flush),
      .rx_flush(rx_flush), .rx_trig_level(rx_trig_level), .tx_trig_level(tx_trig_level),
      .receive_ready(receive_ready), .transmit_ready(transmit_ready),
      .int_pending(int_pending));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, got, err);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      host.xfer(1'b0, a, 32'h0, got, err);
      chk(n, e, got);
   endtask : rd

   // status lags its inputs by two cycles, three for tx_count and the xoff/special pulses, so allow four
   task automatic ist(input logic [7:0] e);
      repeat (4) @(posedge pclk);
      rd(`UFCI_OFS_ISTAT, {24'h0, e}, "interrupt_status");
   endtask : ist

   task automatic lag;
      @(posedge pclk);
      #1;
   endtask : lag

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      rx_count = 8'h00;
      tx_count = 8'h14;
      {rhr_full, txh_empty, txh_write, line_err, rx_timeout, modem_change} = '0;
      {xoff_detect, xon_detect, special_detect, cts_rts_change} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk("fifo_enable", 32'h0, fifo_enable);
      chk("rx_trig_level", 32'h08, rx_trig_level);
      chk("tx_trig_level", 32'h10, tx_trig_level);
      ist(8'h01);
      rd(`UFCI_OFS_FCTL, 32'h0, "fifo_control");
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         wr(`UFCI_OFS_FCTL, {24'h0, i[1:0], i[1:0], 4'h1});
         lag();
         chk("rx_trig_level", rxt[i], rx_trig_level);
         chk("tx_trig_level", txt[i], tx_trig_level);
      end
      chk("fifo_enable", 32'h1, fifo_enable);
      ist(8'hC1);
      wr(`UFCI_OFS_FCTL, 32'h0F);
      #1;
      chk("tx_flush", 32'h1, tx_flush);
      chk("rx_flush", 32'h1, rx_flush);
      lag();
      chk("tx_flush", 32'h0, tx_flush);
      chk("rx_flush", 32'h0, rx_flush);
      rd(`UFCI_OFS_FCTL, 32'h01, "fifo_control");
      for (int i = 0; i < 4; i++)
      begin
         wr(ofs[i], 32'h05);
         lag();
         chk("rx_trig_level", (i == 0) ? 32'h05 : 32'h0, rx_trig_level);
         chk("tx_trig_level", (i == 1) ? 32'h05 : 32'h0, tx_trig_level);
         wr(ofs[i], 32'h00);
      end
      lag();
      chk("rx_trig_level", 32'h08, rx_trig_level);
      host.xfer(1'b0, 8'h20, 32'h0, got, err);
      chk("pslverr", 32'h1, err);
      $display("test fifo_control done");
      // ------------------------------------------------------------
      // interrupt priorities
      // ------------------------------------------------------------
      wr(`UFCI_OFS_IEN, 32'hFF);
      wr(`UFCI_OFS_EFEAT, 32'h10);
      // trigger sweep left transmit-empty armed; reading it clears it
      ist(8'hC2);
      cts_rts_change <= 1'b1;
      ist(8'hE0);
      line_err <= 1'b1;
      ist(8'hE0);
      cts_rts_change <= 1'b0;
      rx_count <= 8'h08;
      rx_timeout <= 1'b1;
      modem_change <= 1'b1;
      tx_count <= 8'h0A;
      xoff_detect <= 1'b1;
      @(posedge pclk);
      xoff_detect <= 1'b0;
      repeat (3) @(posedge pclk);
      cts_rts_change <= 1'b1;
      ist(8'hC6);
      chk("receive_ready", 32'h1, receive_ready);
      chk("transmit_ready", 32'h1, transmit_ready);
      line_err <= 1'b0;
      ist(8'hC4);
      rx_count <= 8'h07;
      ist(8'hCC);
      chk("receive_ready", 32'h0, receive_ready);
      rx_timeout <= 1'b0;
      ist(8'hC2);
      ist(8'hC0);
      chk("int_pending", 32'h1, int_pending);
      modem_change <= 1'b0;
      ist(8'hD0);
      ist(8'hD0);
      xon_detect <= 1'b1;
      @(posedge pclk);
      xon_detect <= 1'b0;
      ist(8'hE0);
      wr(`UFCI_OFS_EFEAT, 32'h00);
      ist(8'hC1);
      chk("int_pending", 32'h0, int_pending);
      wr(`UFCI_OFS_EFEAT, 32'h10);
      cts_rts_change <= 1'b0;
      special_detect <= 1'b1;
      @(posedge pclk);
      special_detect <= 1'b0;
      ist(8'hD0);
      ist(8'hC1);
      tx_count <= 8'h14;
      repeat (4) @(posedge pclk);
      tx_count <= 8'h0A;
      repeat (4) @(posedge pclk);
      txh_write <= 1'b1;
      @(posedge pclk);
      txh_write <= 1'b0;
      ist(8'hC1);
      $display("test priorities done");
      wr(`UFCI_OFS_FCTL, 32'h00);
      rhr_full <= 1'b1;
      ist(8'h04);
      chk("receive_ready", 32'h1, receive_ready);
      rhr_full <= 1'b0;
      txh_empty <= 1'b1;
      ist(8'h02);
      ist(8'h01);
      $display("test non-fifo done");
      end_of_test();
   end

endmodule : tb

`default_nettype wire
